// ===== hw/vic_pkg.sv
// Shared constants and types for the vectored interrupt controller
package vic_pkg;

  // Source and flag counts
  localparam int NUM_SRC  = 16;         // Vectored sources, arbitration order 0..15
  localparam int NUM_FLAG = 17;         // Pending flags; timer two owns two of them

  // AXI4-Lite address width and register byte addresses
  localparam int              ADDR_W        = 8;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE   = 8'hA8; // interrupt_enable_mask
  localparam logic [ADDR_W-1:0] ADDR_PRIO     = 8'hB8; // Primary priority bits
  localparam logic [ADDR_W-1:0] ADDR_EXT_EN1  = 8'hC0; // extended_enable_one
  localparam logic [ADDR_W-1:0] ADDR_EXT_EN2  = 8'hC4; // extended_enable_two
  localparam logic [ADDR_W-1:0] ADDR_EXT_PR1  = 8'hC8; // extended_priority_one
  localparam logic [ADDR_W-1:0] ADDR_EXT_PR2  = 8'hCC; // extended_priority_two
  localparam logic [ADDR_W-1:0] ADDR_PEND_SET = 8'hD0; // Read flags, write 1 to set
  localparam logic [ADDR_W-1:0] ADDR_PEND_CLR = 8'hD4; // Write 1 to clear flags
  localparam logic [ADDR_W-1:0] ADDR_EXT_CFG  = 8'hD8; // External input sense config
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'hDC; // Arbitration and service state

  // Reset values
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [6:0] RST_PRIO   = 7'h00;
  localparam logic [7:0] RST_EXT    = 8'h00;
  localparam logic       RST_EXT2   = 1'b0;
  localparam logic [3:0] RST_CFG    = 4'h0;
  localparam logic [7:0] PRIO_TOP_RD = 8'h80; // Unused top priority bit reads one

  // Primary enable register fields
  localparam int BIT_GLOBAL = 7; // global_irq_enable
  localparam int BIT_SPI    = 6; // serial_periph_irq_mask
  localparam int BIT_T2     = 5; // timer_two_irq_mask
  localparam int BIT_UART   = 4; // uart_irq_mask
  localparam int BIT_T1     = 3; // timer_one_irq_mask
  localparam int BIT_X1     = 2; // ext_input_one_irq_mask
  localparam int BIT_T0     = 1; // timer_zero_irq_mask
  localparam int BIT_X0     = 0; // ext_input_zero_irq_mask

  // Source indices and flag slots
  localparam int SRC_EXT0     = 0;
  localparam int SRC_EXT1     = 2;
  localparam int SRC_T2       = 5;
  localparam int FLAG_T2_LOW  = 5;  // timer_two_low_overflow_flag
  localparam int FLAG_T2_HIGH = 16; // timer_two_high_overflow_flag

  // External input configuration fields
  localparam int CFG_EDGE0 = 0;
  localparam int CFG_POL0  = 1;
  localparam int CFG_EDGE1 = 2;
  localparam int CFG_POL1  = 3;

  // Vector map
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BASE  = 16'h0003;
  localparam int          VEC_SHIFT = 3;       // 8 bytes between vectors

  // Timing counts in system clocks
  localparam int         DETECT_CYCLES = 1;
  localparam logic [1:0] CALL_LAST     = 2'(4 - 1); // Long call lasts 4 clocks

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Sequencer to controller
  typedef struct packed {
    logic instr_done; // Instruction completes this cycle
    logic reti_done;  // Return from service completes this cycle
    logic stall;      // Core stalled (flash or buffer access)
  } vic_cpu_in_t;

  // Controller to sequencer
  typedef struct packed {
    logic        call;   // Long call to vector in progress
    logic        enter;  // First cycle of the service routine
    logic [15:0] vector; // Target address
  } vic_call_t;

  typedef enum logic [0:0] {ST_IDLE, ST_CALL} vic_state_t;

endpackage

// ===== hw/vic_flag_cell.sv
// One pending flag with hardware set, software set and clear
`timescale 1ns/1ps
module vic_flag_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic set_hw,  // Source condition seen
  input  wire logic set_sw,  // Software writes a one
  input  wire logic clr,     // Software or automatic clear
  output logic      flag_q   // Pending state
);

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_q <= RESET_VAL;
    end else if (set_hw || set_sw) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end

endmodule

// ===== hw/vic_top.sv
// Vectored interrupt controller: flags, masks, arbitration and call sequencing
//
// Function
// - Sample and decode requests every clock
// - Best case: detect one, call four clocks
// - After return, one instruction before next call
// - Worst case eighteen clocks without competing service
// - Equal or higher service blocks new request
// - Core stalls stretch latency by stall time
// - Fixed vectors from 0x0003, eight apart
// - Equal level: lower order number wins
// - Global enable bit seven overrides all masks
// - Each source needs its own enable bit
// - Primary enable bits map the first seven sources
// - Timer two enable gates both overflow flags
// - Primary enable at 0xA8, resets zero
// - Extended registers mask and rank remaining sources
// - Edge external flags clear on vectoring
// - High preempts low; high never preempted
// - Flag still set after return re-enters
// - Flags set regardless of enables; software sets
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module vic_top
  import vic_pkg::*;
(
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST,
  input  wire logic [ADDR_W-1:0]    S_AXI_AWADDR,
  input  wire logic                 S_AXI_AWVALID,
  output logic                      S_AXI_AWREADY,
  input  wire logic [31:0]          S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  input  wire logic                 S_AXI_WVALID,
  output logic                      S_AXI_WREADY,
  output logic [1:0]                S_AXI_BRESP,
  output logic                      S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0]    S_AXI_ARADDR,
  input  wire logic                 S_AXI_ARVALID,
  output logic                      S_AXI_ARREADY,
  output logic [31:0]               S_AXI_RDATA,
  output logic [1:0]                S_AXI_RRESP,
  output logic                      S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY,
  input  wire logic [NUM_FLAG-1:0]  SRC_EVENT,
  input  wire logic                 EXT_PIN0,
  input  wire logic                 EXT_PIN1,
  input  wire vic_pkg::vic_cpu_in_t CPU_SEQ,
  output vic_pkg::vic_call_t        IRQ_CALL,
  output logic [NUM_FLAG-1:0]       PEND_FLAGS
);
  import vic_pkg::*;

  // Pin synchroniser stages and edge history
  logic [1:0]          pin_meta_q;   // First stage, read only by second
  logic [1:0]          pin_sync_q;   // Safe pin level
  logic [1:0]          pin_prev_q;   // Previous safe level for edges
  // Software registers
  logic [7:0]          ie_q;         // interrupt_enable_mask
  logic [6:0]          prio_q;       // Primary priority bits
  logic [7:0]          ee1_q;        // extended_enable_one
  logic                ee2_q;        // extended_enable_two
  logic [7:0]          ep1_q;        // extended_priority_one
  logic                ep2_q;        // extended_priority_two
  logic [3:0]          cfg_q;        // External input sense config
  // Bus slave state
  logic                awready_q, wready_q, aw_held_q, w_held_q;
  logic [ADDR_W-1:0]   awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                bvalid_q, arready_q, rvalid_q;
  logic [1:0]          bresp_q, rresp_q;
  logic [31:0]         rdata_q;
  // Flags and arbitration
  logic [NUM_FLAG-1:0] flag_q, hw_set, sw_set, sw_clr, flag_clr;
  logic [NUM_SRC-1:0]  req, en_vec, pr_vec, active;
  logic [1:0]          ext_act, ext_act_prev, ext_set;
  logic                hi_any, lo_any, win_any, win_hi;
  logic [3:0]          hi_id, lo_id, win_id;
  logic                win_vld_q, win_hi_q;
  logic [3:0]          win_id_q;
  // Service sequencing
  vic_state_t          state_q;
  logic [1:0]          cnt_q;
  logic                call_q, enter_q, cur_hi_q, in_hi_q, in_lo_q, hold_q;
  logic [15:0]         vector_q;
  logic [3:0]          cur_id_q;
  logic                allow, take_w, wr_fire;
  logic [31:0]         rd_data;
  logic [1:0]          rd_resp;
  logic [23:0]         lane_mask;

  // Two stages before logic; reset to the idle level of the active-low default, so no false request
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pin_meta_q <= 2'b11;
      pin_sync_q <= 2'b11;
      pin_prev_q <= 2'b11;
    end else begin
      pin_meta_q <= {EXT_PIN1, EXT_PIN0};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // External sense: polarity then edge or level
  always_comb begin
    ext_act[0]      = pin_sync_q[0] == cfg_q[CFG_POL0];
    ext_act[1]      = pin_sync_q[1] == cfg_q[CFG_POL1];
    ext_act_prev[0] = pin_prev_q[0] == cfg_q[CFG_POL0];
    ext_act_prev[1] = pin_prev_q[1] == cfg_q[CFG_POL1];
    ext_set[0] = cfg_q[CFG_EDGE0] ? (ext_act[0] && !ext_act_prev[0]) : ext_act[0];
    ext_set[1] = cfg_q[CFG_EDGE1] ? (ext_act[1] && !ext_act_prev[1]) : ext_act[1];
  end

  // Write strobes per byte lane for the flag registers
  assign lane_mask = {{8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_fire   = aw_held_q && w_held_q && !bvalid_q;

  // Set and clear terms for every flag
  always_comb begin
    hw_set           = SRC_EVENT;
    hw_set[SRC_EXT0] = SRC_EVENT[SRC_EXT0] | ext_set[0];
    hw_set[SRC_EXT1] = SRC_EVENT[SRC_EXT1] | ext_set[1];
    sw_set = '0;
    sw_clr = '0;
    if (wr_fire && awaddr_q == ADDR_PEND_SET) begin
      sw_set = wdata_q[NUM_FLAG-1:0] & lane_mask[NUM_FLAG-1:0];
    end
    if (wr_fire && awaddr_q == ADDR_PEND_CLR) begin
      sw_clr = wdata_q[NUM_FLAG-1:0] & lane_mask[NUM_FLAG-1:0];
    end
    flag_clr = sw_clr;
    // Level inputs drop their flag once the pin goes inactive
    if (!cfg_q[CFG_EDGE0] && !ext_act[0]) begin
      flag_clr[SRC_EXT0] = 1'b1;
    end
    if (!cfg_q[CFG_EDGE1] && !ext_act[1]) begin
      flag_clr[SRC_EXT1] = 1'b1;
    end
    // Edge flags clear as the core vectors to them
    if (take_w && win_id == 4'(SRC_EXT0) && cfg_q[CFG_EDGE0]) begin
      flag_clr[SRC_EXT0] = 1'b1;
    end
    if (take_w && win_id == 4'(SRC_EXT1) && cfg_q[CFG_EDGE1]) begin
      flag_clr[SRC_EXT1] = 1'b1;
    end
  end

  // One flag cell per pending flag
  for (genvar g = 0; g < NUM_FLAG; g++) begin : g_flag
    vic_flag_cell #(.RESET_VAL(1'b0)) u_cell (
      .clk    (SYS_CLK),
      .rst    (RST),
      .set_hw (hw_set[g]),
      .set_sw (sw_set[g]),
      .clr    (flag_clr[g]),
      .flag_q (flag_q[g])
    );
  end
  assign PEND_FLAGS = flag_q;

  // Requests, masks and priorities per source
  always_comb begin
    req         = flag_q[NUM_SRC-1:0];
    req[SRC_T2] = flag_q[FLAG_T2_LOW] | flag_q[FLAG_T2_HIGH];
    en_vec      = {ee2_q, ee1_q, ie_q[BIT_SPI:BIT_X0]};
    pr_vec      = {ep2_q, ep1_q, prio_q};
    active      = req & en_vec & {NUM_SRC{ie_q[BIT_GLOBAL]}};
  end

  // Fixed-order decode, run every clock
  always_comb begin
    hi_any = 1'b0;
    lo_any = 1'b0;
    hi_id  = 4'h0;
    lo_id  = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (active[i] && pr_vec[i]) begin
        hi_any = 1'b1;
        hi_id  = 4'(i);
      end
      if (active[i]) begin
        lo_any = 1'b1;
        lo_id  = 4'(i);
      end
    end
    win_any = hi_any || lo_any;
    win_hi  = hi_any;
    win_id  = hi_any ? hi_id : lo_id;
  end

  // Nested service: only high over low may interrupt a routine
  assign allow = (!in_lo_q && !in_hi_q) || (in_lo_q && !in_hi_q && win_hi);
  // Take at an instruction boundary, never while stalled or just after return
  assign take_w = win_any && allow && CPU_SEQ.instr_done && !CPU_SEQ.reti_done &&
                  !hold_q && !CPU_SEQ.stall && state_q == ST_IDLE;

  // Registered decode result for software visibility
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      win_vld_q <= 1'b0;
      win_hi_q  <= 1'b0;
      win_id_q  <= 4'h0;
    end else begin
      win_vld_q <= win_any;
      win_hi_q  <= win_hi;
      win_id_q  <= win_id;
    end
  end

  // Long call sequencer: detection is the take cycle, then four call clocks
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_q  <= ST_IDLE;
      cnt_q    <= 2'b00;
      call_q   <= 1'b0;
      enter_q  <= 1'b0;
      vector_q <= VEC_RESET;
      cur_id_q <= 4'h0;
      cur_hi_q <= 1'b0;
    end else begin
      enter_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take_w) begin
            state_q  <= ST_CALL;
            call_q   <= 1'b1;
            cnt_q    <= 2'b00;
            cur_id_q <= win_id;
            cur_hi_q <= win_hi;
            vector_q <= VEC_BASE + (16'(win_id) << VEC_SHIFT);
          end
        end
        ST_CALL: begin
          // A stall freezes the call, adding its length to latency
          if (!CPU_SEQ.stall) begin
            if (cnt_q == CALL_LAST) begin
              state_q <= ST_IDLE;
              call_q  <= 1'b0;
              enter_q <= 1'b1;
            end else begin
              cnt_q <= cnt_q + 2'b01;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          call_q  <= 1'b0;
        end
      endcase
    end
  end
  assign IRQ_CALL = '{call: call_q, enter: enter_q, vector: vector_q};

  // In-service levels and the one-instruction hold after a return
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      in_hi_q <= 1'b0;
      in_lo_q <= 1'b0;
      hold_q  <= 1'b0;
    end else begin
      if (CPU_SEQ.reti_done) begin
        // Return always closes the highest open level
        if (in_hi_q) begin
          in_hi_q <= 1'b0;
        end else begin
          in_lo_q <= 1'b0;
        end
        hold_q <= 1'b1;
      end else if (CPU_SEQ.instr_done) begin
        hold_q <= 1'b0;
      end
      if (take_w && win_hi) begin
        in_hi_q <= 1'b1;
      end else if (take_w) begin
        in_lo_q <= 1'b1;
      end
    end
  end

  // Register writes, low byte lane
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ie_q   <= RST_ENABLE;
      prio_q <= RST_PRIO;
      ee1_q  <= RST_EXT;
      ee2_q  <= RST_EXT2;
      ep1_q  <= RST_EXT;
      ep2_q  <= RST_EXT2;
      cfg_q  <= RST_CFG;
    end else if (wr_fire && wstrb_q[0]) begin
      case (awaddr_q)
        ADDR_ENABLE:  ie_q   <= wdata_q[7:0];
        ADDR_PRIO:    prio_q <= wdata_q[6:0];
        ADDR_EXT_EN1: ee1_q  <= wdata_q[7:0];
        ADDR_EXT_EN2: ee2_q  <= wdata_q[0];
        ADDR_EXT_PR1: ep1_q  <= wdata_q[7:0];
        ADDR_EXT_PR2: ep2_q  <= wdata_q[0];
        ADDR_EXT_CFG: cfg_q  <= wdata_q[3:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped addresses answer with an error
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_resp = RESP_OKAY;
    case (S_AXI_ARADDR)
      ADDR_ENABLE:   rd_data = {24'h0, ie_q};
      ADDR_PRIO:     rd_data = {24'h0, PRIO_TOP_RD | {1'b0, prio_q}};
      ADDR_EXT_EN1:  rd_data = {24'h0, ee1_q};
      ADDR_EXT_EN2:  rd_data = {31'h0, ee2_q};
      ADDR_EXT_PR1:  rd_data = {24'h0, ep1_q};
      ADDR_EXT_PR2:  rd_data = {31'h0, ep2_q};
      ADDR_PEND_SET: rd_data = {15'h0, flag_q};
      ADDR_PEND_CLR: rd_data = 32'h0000_0000;
      ADDR_EXT_CFG:  rd_data = {28'h0, cfg_q};
      ADDR_STATUS:   rd_data = {19'h0, win_hi_q, win_id_q, in_hi_q, in_lo_q, call_q, win_vld_q, cur_id_q};
      default:       rd_resp = RESP_SLVERR;
    endcase
  end

  // Write channels: address and data taken in either order, one write at a time
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && awready_q) begin
        awaddr_q  <= S_AXI_AWADDR;
        aw_held_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (S_AXI_WVALID && wready_q) begin
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
        w_held_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (awaddr_q == ADDR_STATUS || awaddr_q[1:0] != 2'b00 ||
                      !(awaddr_q inside {ADDR_ENABLE, ADDR_PRIO, ADDR_EXT_EN1, ADDR_EXT_EN2,
                        ADDR_EXT_PR1, ADDR_EXT_PR2, ADDR_PEND_SET, ADDR_PEND_CLR, ADDR_EXT_CFG}))
                     ? RESP_SLVERR : RESP_OKAY;
      end
      // Ready returns only once the response is taken
      if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Read channel: data one clock after the address is taken
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else if (S_AXI_ARVALID && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_data;
      rresp_q   <= rd_resp;
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY  = wready_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

  // Checks on the sequencing outputs
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  a_call_four_clk: assert property ($rose(call_q) ##0 (!CPU_SEQ.stall)[*4] |=> enter_q && !call_q)
    else $error("call did not last four clocks");
  a_stall_freeze: assert property (call_q && CPU_SEQ.stall |=> call_q && !enter_q)
    else $error("call advanced during stall");
  a_global_gate: assert property ($rose(call_q) |-> $past(ie_q[BIT_GLOBAL]))
    else $error("call taken with global enable off");
  a_source_mask: assert property ($rose(call_q) |-> $past(en_vec[win_id]))
    else $error("call taken for masked source");
  a_vector_map: assert property (call_q |-> vector_q == VEC_BASE + (16'(cur_id_q) << VEC_SHIFT))
    else $error("wrong vector address");
  a_reti_hold: assert property (CPU_SEQ.reti_done |=> !$rose(call_q) ##1 !$rose(call_q))
    else $error("call started without a following instruction");
  a_high_no_pre: assert property ($rose(call_q) |-> !$past(in_hi_q))
    else $error("high level routine preempted");
  a_equal_waits: assert property ($rose(call_q) && $past(in_lo_q) |-> cur_hi_q)
    else $error("equal level preempted a routine");
  a_decode_each: assert property (|active |=> win_vld_q)
    else $error("active request not decoded");

  c_preempt: cover property ($rose(call_q) && cur_hi_q && in_lo_q);
  c_reentry: cover property (CPU_SEQ.reti_done ##[2:20] $rose(call_q));
  c_stalled_call: cover property (call_q && CPU_SEQ.stall ##1 call_q ##[1:10] enter_q);

endmodule

// ===== testbench/vic_cpu_model.sv
// Behavioural CPU sequencer: one-cycle instructions, return and stall on command
`timescale 1ns/1ps
module vic_cpu_model (
  input  wire vic_pkg::vic_call_t call_i,
  input  wire logic     stall_req,
  input  wire logic     reti_req,
  output vic_pkg::vic_cpu_in_t seq_o
);
  import vic_pkg::*;
  // No instruction completes during a call, a stall or a return, as in the real core
  assign seq_o = '{instr_done: !call_i.call && !stall_req && !reti_req,
                   reti_done:  reti_req,
                   stall:      stall_req};
endmodule

// ===== testbench/vic_top_tb.sv
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module vic_top_tb;
  import vic_pkg::*;
  logic                clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic                arready, rvalid, stall_req, reti_req, pin0;
  logic [ADDR_W-1:0]   awaddr, araddr;
  logic [31:0]         wdata, rdata, seed, d, rv;
  logic [1:0]          bresp, rresp, rs, wb;
  logic [NUM_FLAG-1:0] ev, pend, m;
  logic [6:0]          p;
  vic_cpu_in_t         seq;
  vic_call_t           irq;
  int                  miscompares, cmp_count, n;

  vic_top vic_top_i (.SYS_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SRC_EVENT(ev),
    .EXT_PIN0(pin0), .EXT_PIN1(1'b1), .CPU_SEQ(seq), .IRQ_CALL(irq), .PEND_FLAGS(pend));
  vic_cpu_model vic_cpu_model_i (.call_i(irq), .stall_req(stall_req), .reti_req(reti_req), .seq_o(seq));

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Repeatable pseudo-random source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected winner: high level first, then lowest order
  function automatic int win(input logic [16:0] f, input logic [6:0] pr);
    logic [15:0] r;
    logic [15:0] h;
    r = f[15:0];
    h = {9'h000, pr};
    r[SRC_T2] = f[SRC_T2] | f[FLAG_T2_HIGH];
    for (int i = 0; i < 16; i++) if (r[i] && h[i]) return i;
    for (int i = 0; i < 16; i++) if (r[i]) return i;
    return 0;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    @(posedge clk);
    awaddr <= a;
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    wb = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    dv = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Event pulse; a positive k stalls the core for k cycles right after the take
  task automatic fire(input logic [16:0] b, input int k);
    @(posedge clk);
    ev <= b;
    @(posedge clk);
    ev <= '0;
    if (k > 0) begin
      @(posedge clk);
      stall_req <= 1'b1;
      repeat (k) @(posedge clk);
      stall_req <= 1'b0;
    end
  endtask

  // Negative count skips the latency figure
  task automatic wait_enter(input int en, input logic [15:0] ev_v);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!irq.enter && n < 40);
    if (en >= 0) chk(n, en);
    else chk(32'(n < 40), 32'h1);
    chk(32'(irq.vector), 32'(ev_v));
    chk(32'(irq.call), 32'h0);
  endtask

  // Clear every flag unless keep is set, then return from the routine
  task automatic leave(input logic keep);
    if (!keep) wr(ADDR_PEND_CLR, 32'h1FFFF);
    @(posedge clk);
    reti_req <= 1'b1;
    @(posedge clk);
    reti_req <= 1'b0;
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready, stall_req, reti_req} = 8'hFF << 7;
    {awaddr, araddr, wdata, ev} = '0;
    pin0 = 1'b1;
    seed = 32'd81;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_ENABLE, rv, rs); chk(rv, 32'(RST_ENABLE));
    rd(ADDR_PRIO, rv, rs); chk(rv, 32'(PRIO_TOP_RD));
    rd(8'hF0, rv, rs); chk(32'(rs), 32'(RESP_SLVERR));
    d = xs() & 32'hFF;
    wr(ADDR_ENABLE, d);
    chk(32'(wb), 32'(RESP_OKAY));
    wr(ADDR_STATUS, 32'h0);
    chk(32'(wb), 32'(RESP_SLVERR));
    rd(ADDR_ENABLE, rv, rs); chk(rv, d);
    // Pending flag set by software with global, then own, enable off
    wr(ADDR_ENABLE, 32'h7F);
    wr(ADDR_PEND_SET, 32'h2);
    repeat (12) @(posedge clk);
    chk(32'(pend), 32'h2);
    wr(ADDR_ENABLE, 32'h80);
    repeat (12) @(posedge clk);
    chk(32'(irq.vector), 32'(VEC_RESET));
    wr(ADDR_ENABLE, 32'h82);
    wait_enter(-1, 16'h000B);
    leave(1'b0);
    fire(17'h2, 0);
    wait_enter(5 + 1, 16'h000B);
    leave(1'b0);
    fire(17'h2, 3);
    wait_enter(4 + 1, 16'h000B); // all four call clocks still run after the stall
    leave(1'b1);
    wait_enter(5 + 2, 16'h000B);
    leave(1'b0);
    // Random simultaneous requests across all sources but the two external inputs, and both levels
    wr(ADDR_EXT_EN1, 32'hFF);
    wr(ADDR_EXT_EN2, 32'h1);
    wr(ADDR_ENABLE, 32'hFF);
    for (int t = 0; t < 12; t++) begin
      m = (t == 0) ? 17'h10000 : 17'(xs()) & 17'h1FFFA;
      if (m == 0) m = 17'h08000;
      p = 7'(xs());
      wr(ADDR_PRIO, 32'(p));
      wr(ADDR_PEND_SET, 32'(m));
      wait_enter(-1, VEC_BASE + 16'(win(m, p) << VEC_SHIFT));
      leave(1'b0);
    end
    // Edge-sensed input zero, active low: its flag drops as the core vectors
    wr(ADDR_EXT_CFG, 32'h1);
    pin0 <= 1'b0;
    wait_enter(-1, VEC_BASE);
    chk(32'(pend[SRC_EXT0]), 32'h0);
    pin0 <= 1'b1;
    leave(1'b1);
    print_verdict();
  end
endmodule
